// ===== src/uart_mp_top.sv
// Serial port with clear-to-send flow control and multiprocessor addressing.
// APB slave on MCLK; serial pins and clear-to-send come from outside the clock domain.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uart_mp_top import uart_mp_pkg::*; (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CLEAR_TO_SEND_IN_N,
  input wire logic SERIAL_RX_IN,
  output logic SERIAL_TX_OUT
);

  typedef struct packed {
    logic [2:0] cts_sync;
    logic [2:0] rx_sync;
    logic cts_level;
    logic rx_level;
    logic [3:0] ctrl0;
    logic [3:0] ctrl1;
    logic [7:0] addr;
    logic [15:0] baud;
    tx_state_e tx_state;
    logic [3:0] tx_tick;
    logic [3:0] tx_bit;
    logic [8:0] tx_shift;
    logic tx_out;
    rx_state_e rx_state;
    logic [3:0] rx_tick;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic [7:0] rx_data;
    logic rx_mp;
    logic rx_valid;
    logic overrun;
    logic framing;
    logic addressed;
    logic timer_done;
    logic [31:0] prdata;
    logic pslverr;
  } top_s;

  top_s st_reg, st_next;

  logic tick;
  logic fifo_in_valid, fifo_in_ready;
  logic [TX_WORD_W-1:0] fifo_in_data, fifo_out_data;
  logic fifo_out_valid, fifo_out_ready;
  logic access, setup, wr_done, rd_done, data_wr;
  logic baud_enable;

  function automatic logic reg_known(input logic [7:0] a);
    case (a)
      CTRL0_OFS, CTRL1_OFS, STAT0_OFS, STAT1_OFS, ADDR_OFS, BAUD_OFS, DATA_OFS: reg_known = 1'b1;
      default: reg_known = 1'b0;
    endcase
  endfunction

  // Pick out the eight data bits; where they sit in the shift register depends on mode
  function automatic logic [7:0] frame_data(input logic [8:0] sh, input logic mp);
    frame_data = mp ? sh[7:0] : sh[8:1];
  endfunction

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign data_wr = access && PWRITE && (PADDR == DATA_OFS);
  // A write to the data register waits while the FIFO is full
  assign PREADY = !(data_wr && !fifo_in_ready);
  assign wr_done = access && PWRITE && PREADY && !st_reg.pslverr;
  assign rd_done = access && !PWRITE && !st_reg.pslverr;
  assign PRDATA = st_reg.prdata;
  assign PSLVERR = access && st_reg.pslverr;
  assign SERIAL_TX_OUT = st_reg.tx_out;

  assign fifo_in_valid = wr_done && (PADDR == DATA_OFS);
  assign fifo_in_data = {st_reg.ctrl1[C1_MP_TX], PWDATA[7:0]};
  // Ninth bit value is latched with each byte; whether it is sent follows the live multiprocessor enable
  assign baud_enable = st_reg.ctrl0[C0_TX_EN] || st_reg.ctrl0[C0_RX_EN] || st_reg.ctrl1[C1_TIMER];

  uart_tx_fifo #(
    .WIDTH(TX_WORD_W),
    .DEPTH(TX_FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst(SYS_RST),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  uart_baud_gen #(
    .DIV_W(16)
  ) u_baud (
    .clk(MCLK),
    .rst(SYS_RST),
    .enable(baud_enable),
    .divisor(st_reg.baud),
    .tick(tick)
  );

  always_comb begin
    logic [7:0] rdata;
    logic [7:0] got;
    logic accept;
    rdata = 8'h00;
    got = 8'h00;
    accept = 1'b0;
    st_next = st_reg;
    fifo_out_ready = 1'b0;

    // Pin synchronisers: a change counts once stages two and three agree
    st_next.cts_sync = {st_reg.cts_sync[1:0], CLEAR_TO_SEND_IN_N};
    st_next.rx_sync = {st_reg.rx_sync[1:0], SERIAL_RX_IN};
    if (st_reg.cts_sync[1] == st_reg.cts_sync[2]) begin
      st_next.cts_level = !st_reg.cts_sync[2];
    end
    if (st_reg.rx_sync[1] == st_reg.rx_sync[2]) begin
      st_next.rx_level = st_reg.rx_sync[2];
    end

    // Register read data is prepared in the setup cycle
    if (setup) begin
      case (PADDR)
        CTRL0_OFS: rdata = {4'h0, st_reg.ctrl0};
        CTRL1_OFS: rdata = {4'h0, st_reg.ctrl1};
        STAT0_OFS: rdata = {st_reg.cts_level, st_reg.timer_done, st_reg.tx_state != TX_IDLE,
                            st_reg.framing, st_reg.overrun, st_reg.rx_valid,
                            !fifo_in_ready, !fifo_out_valid};
        STAT1_OFS: rdata = {6'h00, st_reg.addressed, st_reg.rx_mp};
        ADDR_OFS: rdata = st_reg.addr;
        BAUD_OFS: rdata = 8'h00;
        DATA_OFS: rdata = st_reg.rx_data;
        default: rdata = 8'h00;
      endcase
      st_next.prdata = {24'h000000, rdata};
      if (PADDR == BAUD_OFS) begin
        st_next.prdata = {16'h0000, st_reg.baud};
      end
      st_next.pslverr = !reg_known(PADDR);
    end

    if (wr_done) begin
      case (PADDR)
        CTRL0_OFS: st_next.ctrl0 = PWDATA[3:0];
        CTRL1_OFS: st_next.ctrl1 = PWDATA[3:0];
        ADDR_OFS: st_next.addr = PWDATA[7:0];
        BAUD_OFS: st_next.baud = PWDATA[15:0];
        STAT0_OFS: begin
          // Write one to clear; a same-cycle event below still wins
          if (PWDATA[S0_OVERRUN]) begin
            st_next.overrun = 1'b0;
          end
          if (PWDATA[S0_FRAMING]) begin
            st_next.framing = 1'b0;
          end
          if (PWDATA[S0_TIMER]) begin
            st_next.timer_done = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (rd_done && PADDR == DATA_OFS) begin
      st_next.rx_valid = 1'b0;
    end

    // Timer only while neither direction of the port needs the divider
    if (tick && st_reg.ctrl1[C1_TIMER] && !st_reg.ctrl0[C0_TX_EN] && !st_reg.ctrl0[C0_RX_EN]) begin
      st_next.timer_done = 1'b1;
    end

    // Transmitter
    case (st_reg.tx_state)
      TX_IDLE: begin
        st_next.tx_out = 1'b1;
        // Level is the flop from the previous clock, one clock ahead of the start
        if (st_reg.ctrl0[C0_TX_EN] && fifo_out_valid &&
            (!st_reg.ctrl0[C0_FCE] || st_reg.cts_level)) begin
          fifo_out_ready = 1'b1;
          st_next.tx_shift = fifo_out_data;
          st_next.tx_state = TX_START;
          st_next.tx_tick = 4'h0;
          st_next.tx_bit = 4'h0;
          st_next.tx_out = 1'b0;
        end
      end
      TX_START: begin
        st_next.tx_out = 1'b0;
        if (tick) begin
          st_next.tx_tick = st_reg.tx_tick + 4'h1;
          if (st_reg.tx_tick == LAST_TICK) begin
            st_next.tx_state = TX_DATA;
            st_next.tx_out = st_reg.tx_shift[0];
          end
        end
      end
      TX_DATA: begin
        // Clear-to-send is not looked at here, so a started character completes
        if (tick) begin
          st_next.tx_tick = st_reg.tx_tick + 4'h1;
          if (st_reg.tx_tick == LAST_TICK) begin
            st_next.tx_shift = {1'b0, st_reg.tx_shift[8:1]};
            st_next.tx_bit = st_reg.tx_bit + 4'h1;
            st_next.tx_out = st_reg.tx_shift[1];
            if (st_reg.tx_bit == LAST_DATA_BIT) begin
              if (st_reg.ctrl1[C1_MP_EN]) begin
                st_next.tx_state = TX_MPBIT;
              end else begin
                st_next.tx_state = TX_STOP;
                st_next.tx_bit = 4'h0;
                st_next.tx_out = 1'b1;
              end
            end
          end
        end
      end
      TX_MPBIT: begin
        // Shift register has moved the ninth stored bit to the bottom
        if (tick) begin
          st_next.tx_tick = st_reg.tx_tick + 4'h1;
          if (st_reg.tx_tick == LAST_TICK) begin
            st_next.tx_state = TX_STOP;
            st_next.tx_bit = 4'h0;
            st_next.tx_out = 1'b1;
          end
        end
      end
      TX_STOP: begin
        st_next.tx_out = 1'b1;
        if (tick) begin
          st_next.tx_tick = st_reg.tx_tick + 4'h1;
          if (st_reg.tx_tick == LAST_TICK) begin
            if (st_reg.ctrl0[C0_STOP2] && st_reg.tx_bit == 4'h0) begin
              st_next.tx_bit = 4'h1;
            end else begin
              st_next.tx_state = TX_IDLE;
            end
          end
        end
      end
      default: begin
        st_next.tx_state = TX_IDLE;
        st_next.tx_out = 1'b1;
      end
    endcase

    // Receiver: ticks count from the middle of the start bit
    case (st_reg.rx_state)
      RX_IDLE: begin
        if (st_reg.ctrl0[C0_RX_EN] && !st_reg.rx_level) begin
          st_next.rx_state = RX_START;
          st_next.rx_tick = 4'h0;
        end
      end
      RX_START: begin
        if (tick) begin
          st_next.rx_tick = st_reg.rx_tick + 4'h1;
          if (st_reg.rx_tick == MID_TICK) begin
            // A line back high mid start bit is a glitch, not a frame
            st_next.rx_state = st_reg.rx_level ? RX_IDLE : RX_DATA;
            st_next.rx_tick = 4'h0;
            st_next.rx_bit = 4'h0;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          st_next.rx_tick = st_reg.rx_tick + 4'h1;
          if (st_reg.rx_tick == LAST_TICK) begin
            st_next.rx_shift = {st_reg.rx_level, st_reg.rx_shift[8:1]};
            st_next.rx_bit = st_reg.rx_bit + 4'h1;
            if (st_reg.rx_bit == (st_reg.ctrl1[C1_MP_EN] ? MP_BIT_POS : LAST_DATA_BIT)) begin
              st_next.rx_state = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          st_next.rx_tick = st_reg.rx_tick + 4'h1;
          if (st_reg.rx_tick == LAST_TICK) begin
            st_next.rx_state = RX_IDLE;
            got = frame_data(st_reg.rx_shift, st_reg.ctrl1[C1_MP_EN]);
            accept = 1'b1;
            if (st_reg.ctrl1[C1_MP_EN] && st_reg.ctrl1[C1_AUTO]) begin
              if (st_reg.rx_shift[8]) begin
                // Address frame: match decides this and the following data frames
                accept = (got == st_reg.addr);
                st_next.addressed = accept;
              end else begin
                accept = st_reg.addressed;
              end
            end
            if (accept) begin
              if (!st_reg.rx_level) begin
                st_next.framing = 1'b1;
              end
              if (st_next.rx_valid) begin
                st_next.overrun = 1'b1;
              end
              st_next.rx_data = got;
              st_next.rx_mp = st_reg.ctrl1[C1_MP_EN] && st_reg.rx_shift[8];
              st_next.rx_valid = 1'b1;
            end
          end
        end
      end
      default: st_next.rx_state = RX_IDLE;
    endcase

    if (!st_reg.ctrl0[C0_RX_EN]) begin
      st_next.rx_state = RX_IDLE;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_reg <= '0;
      st_reg.cts_sync <= 3'b111;
      st_reg.rx_sync <= 3'b111;
      st_reg.rx_level <= 1'b1;
      st_reg.ctrl0 <= CTRL0_RESET;
      st_reg.ctrl1 <= CTRL1_RESET;
      st_reg.addr <= ADDR_RESET;
      st_reg.baud <= BAUD_RESET;
      st_reg.tx_state <= TX_IDLE;
      st_reg.tx_out <= 1'b1;
      st_reg.rx_state <= RX_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// ===== src/uart_mp_pkg.sv
// Constants, register map and state encodings for the flow-controlled
// multiprocessor serial port. Assumes a 100 MHz system clock and an APB master.
package uart_mp_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] LAST_TICK = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] MID_TICK = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] MP_BIT_POS = 4'h8;
  localparam int TX_FIFO_DEPTH = 32;
  localparam int TX_WORD_W = 9;

  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] CTRL1_OFS = 8'h04;
  localparam logic [7:0] STAT0_OFS = 8'h08;
  localparam logic [7:0] STAT1_OFS = 8'h0c;
  localparam logic [7:0] ADDR_OFS = 8'h10;
  localparam logic [7:0] BAUD_OFS = 8'h14;
  localparam logic [7:0] DATA_OFS = 8'h18;

  localparam int C0_TX_EN = 0;
  localparam int C0_RX_EN = 1;
  localparam int C0_FCE = 2;
  localparam int C0_STOP2 = 3;
  localparam int C1_MP_EN = 0;
  localparam int C1_MP_TX = 1;
  localparam int C1_AUTO = 2;
  localparam int C1_TIMER = 3;
  localparam int S0_TX_EMPTY = 0;
  localparam int S0_TX_FULL = 1;
  localparam int S0_RX_VALID = 2;
  localparam int S0_OVERRUN = 3;
  localparam int S0_FRAMING = 4;
  localparam int S0_TX_BUSY = 5;
  localparam int S0_TIMER = 6;
  localparam int S0_CTS = 7;
  localparam int S1_RX_MP = 0;
  localparam int S1_ADDRESSED = 1;

  localparam logic [3:0] CTRL0_RESET = 4'h0;
  localparam logic [3:0] CTRL1_RESET = 4'h0;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [15:0] BAUD_RESET = 16'h0001;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_MPBIT = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_e;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_e;

endpackage

// ===== src/uart_tx_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module uart_tx_fifo import uart_mp_pkg::*; #(
  parameter int WIDTH = TX_WORD_W,
  parameter int DEPTH = TX_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("uart_tx_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } fifo_s;

  fifo_s st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = (st_reg.wr_ptr[AW-1:0] != st_reg.rd_ptr[AW-1:0]) || (st_reg.wr_ptr[AW] == st_reg.rd_ptr[AW]);
  assign out_valid = st_reg.wr_ptr != st_reg.rd_ptr;
  assign out_data = mem[st_reg.rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (push) begin
      mem[st_reg.wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== src/uart_baud_gen.sv
// Divider that gives one pulse every divisor clocks.
// Used as the 16x oversampling strobe or, alone, as a basic timer.
`timescale 1ns/1ps
`default_nettype none
module uart_baud_gen #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);
  generate
    if (DIV_W < 2) begin : g_bad_width
      $error("uart_baud_gen: DIV_W must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic tick;
  } baud_s;

  baud_s st_reg, st_next;

  assign tick = st_reg.tick;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!enable) begin
      st_next.count = '0;
    end else if (st_reg.count + 1'b1 >= divisor) begin
      // Divisor of zero behaves as one so the strobe never stops
      st_next.count = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.count = st_reg.count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/uart_mp_props.sv
// Checker for the serial port: APB replies, bit timing and clear-to-send gating.
// Sees only the top ports; tracks the written flow-control and divisor values itself.
`timescale 1ns/1ps
`default_nettype none
module uart_mp_props import uart_mp_pkg::*; (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CLEAR_TO_SEND_IN_N,
  input wire logic SERIAL_RX_IN,
  input wire logic SERIAL_TX_OUT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  logic acc, mapped, wdone, fce_reg;
  logic [15:0] baud_reg;
  logic [23:0] hi_reg, lim;
  logic [3:0] lo_reg, cts_reg;
  assign acc = PSEL && PENABLE;
  assign wdone = acc && PREADY && PWRITE;
  assign mapped = PADDR inside {CTRL0_OFS, CTRL1_OFS, STAT0_OFS, STAT1_OFS, ADDR_OFS, BAUD_OFS, DATA_OFS};
  // Longest high run inside a frame is eleven bits, so more than twelve means idle
  assign lim = 24'(baud_reg == 16'h0 ? 16'h1 : baud_reg) * 24'hc0;
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      fce_reg <= 1'b0;
      baud_reg <= BAUD_RESET;
      hi_reg <= 24'h0;
      lo_reg <= 4'h0;
      cts_reg <= 4'h0;
    end else begin
      if (wdone && PADDR == CTRL0_OFS) fce_reg <= PWDATA[C0_FCE];
      if (wdone && PADDR == BAUD_OFS) baud_reg <= PWDATA[15:0];
      hi_reg <= SERIAL_TX_OUT ? hi_reg + 24'(hi_reg != 24'hffffff) : 24'h0;
      lo_reg <= SERIAL_TX_OUT ? 4'h0 : lo_reg + 4'h1;
      cts_reg <= CLEAR_TO_SEND_IN_N ? cts_reg + 4'(cts_reg != 4'hf) : 4'h0;
    end
  end
  AST_PREADY_IDLE: assert property (
    !acc |-> PREADY)
    else $error("ready low outside an access");
  AST_UNMAPPED_ERR: assert property (
    acc && !mapped |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (
    acc && mapped |-> !PSLVERR)
    else $error("mapped access refused");
  AST_STALL_DATA_ONLY: assert property (
    acc && !PREADY |-> PWRITE && PADDR == DATA_OFS)
    else $error("wait state on a non-data access");
  AST_RESET_IDLE: assert property (
    $past(SYS_RST) |-> SERIAL_TX_OUT && PRDATA == 32'h0)
    else $error("outputs not idle after reset");
  AST_START_LEN: assert property (
    $fell(SERIAL_TX_OUT) |-> !SERIAL_TX_OUT [*8] ##1 !SERIAL_TX_OUT [*8])
    else $error("low bit shorter than sixteen clocks");
  AST_BIT_GRID: assert property (
    $rose(SERIAL_TX_OUT) |-> lo_reg == 4'h0)
    else $error("low run not a whole number of bits");
  AST_CTS_GATES: assert property (
    fce_reg && cts_reg == 4'hf && SERIAL_TX_OUT && hi_reg > lim |=> SERIAL_TX_OUT)
    else $error("character started without clear-to-send");
  COV_STALL: cover property (acc && !PREADY);
  COV_REFUSED: cover property (acc && PSLVERR);
  COV_GATED_START: cover property ($fell(SERIAL_TX_OUT) && fce_reg && hi_reg > lim);
endmodule
bind uart_mp_top uart_mp_props chk (.MCLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .PREADY, .PSLVERR, .CLEAR_TO_SEND_IN_N, .SERIAL_RX_IN, .SERIAL_TX_OUT);
`default_nettype wire

// ===== testbench/uart_peer_model.sv
// Another node on the shared serial line: decodes frames and sends frames on request.
// Assumes a divisor of 1, so sixteen clocks per bit; its line rests high.
`timescale 1ns/1ps
`default_nettype none
module uart_peer_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic line_in,
  input wire logic nine,
  output logic line_out,
  output logic [8:0] got_word,
  output logic got_stb
);
  logic [8:0] w;
  initial begin
    line_out = 1'b1;
    got_word = 9'h0;
    got_stb = 1'b0;
  end
  // Start, data LSB first, address flag after the data, then stop
  task automatic send(input logic [8:0] f);
    logic [10:0] bits;
    bits = nine ? {1'b1, f, 1'b0} : {2'b11, f[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      line_out <= bits[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask
  // Mid-bit sampling keeps clear of the edges where the line moves
  initial forever begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk);
    if (!line_in) begin
      w = 9'h0;
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (BIT_CLKS) @(posedge clk);
        w[i] = line_in;
      end
      repeat (BIT_CLKS) @(posedge clk);
      got_word <= w;
      got_stb <= 1'b1;
      @(posedge clk);
      got_stb <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/test_uart_flow_control_multiproc.sv
// Self-checking bench: APB master, peer node, read and frame scoreboards.
// Assumes divisor 1 while serial traffic runs.
`timescale 1ns/1ps
`default_nettype none
module test_uart_flow_control_multiproc import uart_mp_pkg::*; ();
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cts_n = 1'b1, nine = 1'b1, rd_chk = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rq, b;
  logic [31:0] seed = 32'h2a;
  logic pready, pslverr, tx, rx, stb;
  logic [8:0] word;
  logic [64:0] nt;
  logic [64:0] note_q[$];
  logic [8:0] tx_q[$];
  int failures = 0, n_checks = 0, n_got = 0;
  always #5 mclk = ~mclk;
  uart_mp_top dut (.MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CLEAR_TO_SEND_IN_N(cts_n), .SERIAL_RX_IN(rx), .SERIAL_TX_OUT(tx));
  uart_peer_model peer (.clk(mclk), .line_in(tx), .nine(nine), .line_out(rx), .got_word(word), .got_stb(stb));
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Access ends at the rising edge where ready is seen high
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rq = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    rd_chk <= 1'b0;
    @(posedge mclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask = 32'hffffffff,
          input logic err = 1'b0);
    note_q.push_back({err, mask, exp});
    rd_chk <= 1'b1;
    apb(1'b0, a, 32'h0);
  endtask
  task wait_got(input int target);
    for (int i = 0; i < 20000 && n_got < target; i++) @(posedge mclk);
    check("frame count", n_got, target);
  endtask
  task give_verdict();
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (rd_chk && psel && penable && pready === 1'b1) begin
      nt = note_q.pop_front();
      check("read data", prdata & nt[63:32], nt[31:0]);
      check("slave error", 32'(pslverr), 32'(nt[64]));
    end
  end
  always @(posedge stb) begin
    n_got++;
    check("frame", 32'(word), tx_q.size() > 0 ? 32'(tx_q.pop_front()) : 32'hffffffff);
  end
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(CTRL0_OFS, 32'(CTRL0_RESET));
    rd(CTRL1_OFS, 32'(CTRL1_RESET));
    rd(ADDR_OFS, 32'(ADDR_RESET));
    rd(BAUD_OFS, 32'(BAUD_RESET));
    rd(8'h1c, 32'h0, 32'hffffffff, 1'b1);
    wr(CTRL1_OFS, 32'h3);
    rd(CTRL1_OFS, 32'h3);
    wr(CTRL0_OFS, 32'h1);
    // Clear-to-send held off but ignored; enough bytes to overfill the FIFO
    for (int i = 0; i < 36; i++) begin
      if (i == 1) wr(CTRL1_OFS, 32'h1);
      b = xs();
      tx_q.push_back({i == 0, b[7:0]});
      wr(DATA_OFS, {24'h0, b[7:0]});
    end
    wait_got(36);
    cts_n <= 1'b0;
    wr(CTRL0_OFS, 32'h5);
    for (int i = 0; i < 2; i++) begin
      b = xs();
      tx_q.push_back({1'b0, b[7:0]});
      wr(DATA_OFS, {24'h0, b[7:0]});
    end
    for (int i = 0; i < 400 && tx; i++) @(posedge mclk);
    cts_n <= 1'b1;
    wait_got(37);
    repeat (600) @(posedge mclk);
    check("held frame", n_got, 37);
    cts_n <= 1'b0;
    wait_got(38);
    // Plain eight-bit frame with two stop bits: no ninth bit on the line
    nine <= 1'b0;
    wr(CTRL1_OFS, 32'h0);
    wr(CTRL0_OFS, 32'h9);
    b = xs();
    tx_q.push_back({1'b0, b[7:0]});
    wr(DATA_OFS, {24'h0, b[7:0]});
    wait_got(39);
    nine <= 1'b1;
    wr(CTRL0_OFS, 32'h2);
    wr(CTRL1_OFS, 32'h5);
    wr(ADDR_OFS, 32'h5a);
    peer.send(9'h133);
    peer.send(9'h011);
    repeat (8) @(posedge mclk);
    rd(STAT0_OFS, 32'h0, 32'h4);
    b = xs();
    peer.send(9'h15a);
    peer.send({1'b0, b[7:0]});
    repeat (8) @(posedge mclk);
    rd(STAT1_OFS, 32'h2, 32'h3);
    rd(DATA_OFS, {24'h0, b[7:0]}, 32'hff);
    peer.send(9'h133);
    peer.send(9'h022);
    repeat (8) @(posedge mclk);
    rd(STAT0_OFS, 32'h0, 32'h4);
    rd(STAT1_OFS, 32'h0, 32'h2);
    wr(CTRL0_OFS, 32'h0);
    wr(BAUD_OFS, 32'h20);
    wr(CTRL1_OFS, 32'h8);
    repeat (40) @(posedge mclk);
    rd(STAT0_OFS, 32'h40, 32'h40);
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire
